// file: dac_i2c_command_error_general_call_test.sv
// Self-checking bench for the DAC I2C command slave with a master model.
// Assumes RES of 12 and the slave address default; SDA has a pull-up.
`include "dgc_defines.svh"
`timescale 1ns/1ps
module dac_i2c_command_error_general_call_test;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic storeWriteBusy = 1'b0;
  logic sclClk, sdaDrv, sdaOut, sdaOe_n, storeReload, powerDownClear, outputHold;
  logic [15:0] volRegData [0:31];
  logic [31:0] addrValid = 32'h0000_0723;
  logic [31:0] addrVolatile = 32'h0000_0701;
  logic [4:0] rdAddr;
  logic [1:0] cmdType;
  logic [3:0] pdMask;
  int error_cnt = 0;
  int cmp_count = 0;
  int rlCnt = 0;
  int pdCnt = 0;
  int holdCnt = 0;
  wire sdaBus = sdaDrv & (sdaOe_n | sdaOut);

  dgc_i2c_master m (.sclClk(sclClk), .sdaDrv(sdaDrv), .sdaBus(sdaBus));
  dgc_i2c_slave dut (.clock(clock), .arst_n(arst_n), .clkEn(1'b1), .sclClk(sclClk),
    .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .storeWriteBusy(storeWriteBusy),
    .volRegData(volRegData), .addrValid(addrValid), .addrVolatile(addrVolatile),
    .rdAddr(rdAddr), .cmdType(cmdType), .storeReload(storeReload),
    .powerDownClear(powerDownClear), .outputHold(outputHold),
    .channelPowerDownSelectMask(pdMask));

  initial begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (storeReload === 1'b1) rlCnt++;
    if (powerDownClear === 1'b1) pdCnt++;
    if (outputHold === 1'b1) holdCnt++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [4:0] addr, input logic [1:0] op, output logic a);
    logic a0;
    m.start();
    m.wbyte(8'hC0, a0);
    chk(16'(a0), 16'h0000);
    m.wbyte({addr, op, 1'b0}, a);
  endtask : cmd
  task automatic rdWord(output logic [15:0] w);
    logic a;
    m.start();
    m.wbyte(8'hC1, a);
    chk(16'(a), 16'h0000);
    m.rbyte(1'b0, w[15:8]);
    m.rbyte(1'b1, w[7:0]);
    m.stop();
  endtask : rdWord
  task automatic t_nolast;
    logic a;
    m.start();
    m.wbyte(8'hC1, a);
    chk(16'(a), 16'h0001);
    m.stop();
    $display("read-last test done");
  endtask : t_nolast
  task automatic t_read;
    logic a;
    logic [15:0] w;
    cmd(5'h05, `DGC_CMD_READ, a);
    chk(16'(a), 16'h0000);
    rdWord(w);
    chk(w, 16'h0A55);
    chk(16'(rdAddr), 16'h0005);
    rdWord(w);
    chk(w, 16'h0A55);
    $display("read test done");
  endtask : t_read
  task automatic t_err;
    logic a;
    logic [15:0] w;
    cmd(5'h09, 2'h1, a);
    chk(16'(a), 16'h0001);
    m.wbyte(8'h2E, a);
    chk(16'(a), 16'h0001);
    rdWord(w);
    chk(w, 16'h0A55);
    $display("error test done");
  endtask : t_err
  task automatic t_busy;
    logic a;
    @(posedge clock);
    storeWriteBusy <= 1'b1;
    cmd(5'h05, `DGC_CMD_READ, a);
    chk(16'(a), 16'h0001);
    cmd(5'h00, `DGC_CMD_READ, a);
    chk(16'(a), 16'h0000);
    m.stop();
    @(posedge clock);
    storeWriteBusy <= 1'b0;
    $display("busy test done");
  endtask : t_busy
  task automatic t_gc;
    logic [7:0] codes [5] = '{`DGC_GC_RESET, `DGC_GC_WAKE, `DGC_GC_UNSUP_A,
      `DGC_GC_UNSUP_B, 8'h01};
    logic a;
    int r0, p0, h0;
    for (int i = 0; i < 5; i++) begin
      r0 = rlCnt;
      p0 = pdCnt;
      h0 = holdCnt;
      m.start();
      m.wbyte(`DGC_GC_ADDR, a);
      chk(16'(a), 16'h0000);
      m.wbyte(codes[i], a);
      chk(16'(a), 16'(i > 1));
      if (i == 4) begin
        m.wbyte(`DGC_GC_RESET, a);
        chk(16'(a), 16'h0001);
      end
      m.stop();
      // Pulses land a few cycles after the ACK; hold runs its full sequence
      repeat (40) @(posedge clock);
      #1;
      chk(16'(rlCnt - r0), 16'(i == 0));
      chk(16'(pdCnt - p0), 16'(i == 1));
      chk(16'(holdCnt - h0), (i == 0) ? 16'h0010 : 16'h0000);
    end
    $display("general call test done");
  endtask : t_gc
  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    for (int i = 0; i < 32; i++) volRegData[i] = 16'hFA50 + 16'(i);
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_nolast();
    t_read();
    t_err();
    t_busy();
    t_gc();
    tally_and_finish();
  end
  initial begin
    #100000;
    error_cnt++;
    $display("BAD t=%0t timeout", $time);
    tally_and_finish();
  end
endmodule : dac_i2c_command_error_general_call_test

// file: dgc_defines.svh
// Constants for the DAC I2C command, error and general call slave.
// Assumes inclusion by bare name from design files and the bench.
// Contract
// R1 - Invalid command: release SDA, wait Start
// R2 - Bits above resolution read as zero
// R3 - Keep last received memory address
// R4 - NACK read-last when address unreadable
// R5 - After read error NACK until Start
// R6 - Error read returns last valid address
// R7 - ACK general call, decode second byte
// R8 - Hardware general call ignored until Stop
// R9 - NACK general call codes 04h, 00h
// R10 - Reset code: ACK, reload from store
// R11 - General call reset skips delay timer
// R12 - Output held until reset sequence done
// R13 - Wake-up code: ACK, clear power-down
// R14 - Master reads via command, Restart, read
// R15 - Master ends read with NACK, Stop
// R16 - During store write only volatile reads
// R17 - Read word MSB first, sample ACK
// R18 - General call decoder cleared on Start
`ifndef DGC_DEFINES_SVH
`define DGC_DEFINES_SVH
`define DGC_GC_ADDR 8'h00
`define DGC_GC_RESET 8'h06
`define DGC_GC_WAKE 8'h0A
`define DGC_GC_UNSUP_A 8'h04
`define DGC_GC_UNSUP_B 8'h00
`define DGC_CMD_READ 2'h3
`define DGC_CMD_WRITE 2'h0
`define DGC_POR_SEQ_CYCLES 8'h10
`define DGC_RES_DEFAULT 12
`endif

// file: dgc_i2c_master.sv
// I2C bus master model: drives SCL and an open-drain pull-down on SDA.
// Assumes the bench resolves SDA with a pull-up; SCL idles high between frames.
`timescale 1ns/1ps
module dgc_i2c_master (
  output logic sclClk,
  output logic sdaDrv,
  input wire logic sdaBus
);
  initial begin
    sclClk = 1'b1;
    sdaDrv = 1'b1;
    // One SCL pulse while reset is held, no frame
    #20 sclClk = 1'b0;
    #3 sclClk = 1'b1;
  end
  // Data moves only while SCL is low, so no false Start or Stop
  task automatic bitClk(input logic b, output logic s);
    #1 sdaDrv = b;
    #2 sclClk = 1'b1;
    #2 s = sdaBus;
    #1 sclClk = 1'b0;
  endtask : bitClk
  task automatic start;
    #1 sdaDrv = 1'b1;
    #2 sclClk = 1'b1;
    #3 sdaDrv = 1'b0;
    #3 sclClk = 1'b0;
  endtask : start
  task automatic stop;
    #1 sdaDrv = 1'b0;
    #2 sclClk = 1'b1;
    #3 sdaDrv = 1'b1;
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitClk(d[i], s);
    bitClk(1'b1, ack);
  endtask : wbyte
  task automatic rbyte(input logic ackBit, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitClk(1'b1, d[i]);
    bitClk(ackBit, s);
  endtask : rbyte
endmodule : dgc_i2c_master

// file: dgc_i2c_slave.sv
// I2C slave command handling: errors, reads, general call reset and wake.
// Assumes SCL is the link clock; SDA sampled on SCL, Start/Stop seen on SDA edges.
`include "dgc_defines.svh"
`timescale 1ns/1ps
module dgc_i2c_slave #(
  parameter int RES = `DGC_RES_DEFAULT,
  parameter int CHANNELS = 2,
  parameter logic [6:0] SLAVE_ADDR = 7'h60
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic sclClk,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  input wire logic storeWriteBusy,
  input wire logic [15:0] volRegData [0:31],
  input wire logic [31:0] addrValid,
  input wire logic [31:0] addrVolatile,
  output logic [4:0] rdAddr,
  output logic [1:0] cmdType,
  output logic storeReload,
  output logic powerDownClear,
  output logic outputHold,
  output logic [CHANNELS*2-1:0] channelPowerDownSelectMask
);
  initial begin
    if (RES != 8 && RES != 10 && RES != 12) $error("RES must be 8, 10 or 12");
    if (CHANNELS < 1 || CHANNELS > 2) $error("CHANNELS must be 1 or 2");
  end

  typedef struct packed {
    dgc_pkg::dgc_state_t st;
    logic [7:0] shift;
    logic [3:0] bitCnt;
    logic rnw;
    logic gcActive;
    logic errLatched;
    logic lastValid;
    logic [4:0] lastAddr;
    logic [15:0] txWord;
    logic txSecond;
    logic sdaDrv;
    logic gcRstTgl;
    logic gcWakeTgl;
  } dgc_link_state_t;

  dgc_link_state_t l_q;
  dgc_link_state_t l_d;

  // Start/Stop detectors: SDA edges while SCL high, clocked by SDA itself
  logic startTgl_q;
  logic stopTgl_q;
  logic startSeen_q;
  logic stopSeen_q;
  always_ff @(negedge sdaIn or negedge arst_n) begin
    if (!arst_n) begin
      startTgl_q <= 1'b0;
    end else if (sclClk) begin
      startTgl_q <= ~startTgl_q;
    end
  end
  always_ff @(posedge sdaIn or negedge arst_n) begin
    if (!arst_n) begin
      stopTgl_q <= 1'b0;
    end else if (sclClk) begin
      stopTgl_q <= ~stopTgl_q;
    end
  end
  logic startRef_q;
  logic stopRef_q;
  always_ff @(negedge sclClk or negedge arst_n) begin
    if (!arst_n) begin
      startRef_q <= 1'b0;
      stopRef_q <= 1'b0;
    end else begin
      startRef_q <= startTgl_q;
      stopRef_q <= stopTgl_q;
    end
  end
  dgc_pkg::dgc_cond_t cond;
  assign cond.start = startRef_q != startTgl_q;
  assign cond.stop = stopRef_q != stopTgl_q;

  function automatic logic [15:0] maskWord(input logic [15:0] w);
    logic [15:0] m;
    m = (16'h0001 << RES) - 16'h0001;
    return w & m; // [R2]
  endfunction

  logic [7:0] nextByte;
  logic [4:0] cmdAddr;
  logic [1:0] cmdOp;
  logic readable;
  always_comb begin
    nextByte = {l_q.shift[6:0], sdaIn};
    cmdAddr = nextByte[7:3];
    cmdOp = nextByte[2:1];
    readable = addrValid[cmdAddr] && (!storeWriteBusy || addrVolatile[cmdAddr]); // [R16]
  end

  // Link state moves on SCL fall; the 8th bit decides the ACK so it stands in time
  always_comb begin
    l_d = l_q;
    if (cond.start) begin
      // Fresh transaction clears errors and general call state
      l_d.st = dgc_pkg::DGC_ADDR; // [R1] [R5] [R18]
      l_d.bitCnt = 4'h0;
      l_d.gcActive = 1'b0;
      l_d.errLatched = 1'b0;
      l_d.sdaDrv = 1'b0;
    end else if (cond.stop) begin
      l_d.st = dgc_pkg::DGC_IDLE; // [R8]
      l_d.sdaDrv = 1'b0;
    end else begin
      unique case (l_q.st)
        dgc_pkg::DGC_IDLE, dgc_pkg::DGC_IGNORE, dgc_pkg::DGC_NACK_WAIT: begin
          l_d.sdaDrv = 1'b0; // [R1] [R5] [R8]
        end
        dgc_pkg::DGC_ADDR, dgc_pkg::DGC_CMD, dgc_pkg::DGC_WR_BYTE,
        dgc_pkg::DGC_GC_BYTE: begin
          l_d.sdaDrv = 1'b0;
          l_d.shift = nextByte;
          l_d.bitCnt = 4'(l_q.bitCnt + 4'h1);
          if (l_q.bitCnt == 4'h7) begin
            l_d.bitCnt = 4'h0;
            if (l_q.st == dgc_pkg::DGC_ADDR) begin
              l_d.rnw = nextByte[0];
              l_d.st = dgc_pkg::DGC_IGNORE;
              if (nextByte == `DGC_GC_ADDR) begin
                l_d.gcActive = 1'b1; // [R7]
                l_d.sdaDrv = 1'b1;
                l_d.st = dgc_pkg::DGC_ADDR_ACK;
              end else if (nextByte[7:1] == SLAVE_ADDR &&
                           (!nextByte[0] || l_q.lastValid)) begin
                // Read-last of an unreadable address stays unacknowledged [R4]
                l_d.sdaDrv = 1'b1;
                l_d.st = dgc_pkg::DGC_ADDR_ACK;
                l_d.txWord = maskWord(volRegData[l_q.lastAddr]); // [R3] [R6] [R14]
                l_d.txSecond = 1'b0;
              end
            end else if (l_q.st == dgc_pkg::DGC_CMD) begin
              if ((cmdOp == `DGC_CMD_READ && readable) ||
                  (cmdOp == `DGC_CMD_WRITE && addrValid[cmdAddr])) begin
                // Only an accepted command moves the address; errors keep the old one
                l_d.lastAddr = cmdAddr; // [R3] [R6]
                l_d.lastValid = readable;
                l_d.sdaDrv = 1'b1;
                l_d.st = dgc_pkg::DGC_CMD_ACK;
              end else begin
                l_d.errLatched = 1'b1; // [R5]
                l_d.st = dgc_pkg::DGC_NACK_WAIT; // [R1]
              end
            end else if (l_q.st == dgc_pkg::DGC_WR_BYTE) begin
              l_d.sdaDrv = 1'b1;
              l_d.st = dgc_pkg::DGC_WR_ACK;
            end else if (!nextByte[0] &&
                         (nextByte == `DGC_GC_RESET || nextByte == `DGC_GC_WAKE)) begin
              l_d.sdaDrv = 1'b1; // [R10] [R13]
              l_d.st = dgc_pkg::DGC_GC_ACK;
            end else begin
              // Hardware call, 04h, 00h and the rest: no ACK, ignored [R8] [R9]
              l_d.st = dgc_pkg::DGC_IGNORE;
            end
          end
        end
        dgc_pkg::DGC_ADDR_ACK: begin
          l_d.sdaDrv = 1'b0;
          if (l_q.gcActive) begin
            l_d.st = dgc_pkg::DGC_GC_BYTE;
          end else if (l_q.rnw) begin
            l_d.sdaDrv = ~l_q.txWord[15]; // [R17]
            l_d.st = dgc_pkg::DGC_RD_BYTE;
          end else begin
            l_d.st = dgc_pkg::DGC_CMD;
          end
        end
        dgc_pkg::DGC_CMD_ACK: begin
          l_d.sdaDrv = 1'b0;
          l_d.st = dgc_pkg::DGC_IDLE;
          if (l_q.shift[2:1] == `DGC_CMD_WRITE) begin
            l_d.st = dgc_pkg::DGC_WR_BYTE;
          end
        end
        dgc_pkg::DGC_WR_ACK: begin
          l_d.sdaDrv = 1'b0;
          l_d.st = dgc_pkg::DGC_WR_BYTE;
        end
        dgc_pkg::DGC_GC_ACK: begin
          // Action fires once the ACK clock has ended
          l_d.sdaDrv = 1'b0;
          l_d.st = dgc_pkg::DGC_IGNORE;
          if (l_q.shift == `DGC_GC_RESET) begin
            l_d.gcRstTgl = ~l_q.gcRstTgl; // [R10]
          end else begin
            l_d.gcWakeTgl = ~l_q.gcWakeTgl; // [R13]
          end
        end
        dgc_pkg::DGC_RD_BYTE: begin
          l_d.bitCnt = 4'(l_q.bitCnt + 4'h1);
          l_d.sdaDrv = ~l_q.txWord[{~l_q.txSecond, 3'(3'h6 - l_q.bitCnt[2:0])}]; // [R17]
          if (l_q.bitCnt == 4'h7) begin
            l_d.bitCnt = 4'h0;
            l_d.sdaDrv = 1'b0;
            l_d.st = dgc_pkg::DGC_RD_ACK;
          end
        end
        dgc_pkg::DGC_RD_ACK: begin
          // Master NACK ends the read, ACK starts the other byte [R15] [R17]
          l_d.txSecond = ~l_q.txSecond;
          l_d.sdaDrv = ~l_q.txWord[{l_q.txSecond, 3'h7}];
          l_d.st = dgc_pkg::DGC_RD_BYTE;
          if (sdaIn) begin
            l_d.sdaDrv = 1'b0;
            l_d.st = dgc_pkg::DGC_IDLE;
          end
        end
        default: begin
          l_d.st = dgc_pkg::DGC_IGNORE;
        end
      endcase
    end
  end

  always_ff @(negedge sclClk or negedge arst_n) begin
    if (!arst_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Open drain: enable low drives SDA low
  assign sdaOut = 1'b0;
  assign sdaOe_n = ~l_q.sdaDrv;
  assign rdAddr = l_q.lastAddr;
  assign cmdType = l_q.shift[2:1];

  // System-domain side of general call actions
  logic rstPulse;
  logic wakePulse;
  dgc_sync_pulse uRst (
    .clock(clock),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .srcToggle(l_q.gcRstTgl),
    .pulse(rstPulse)
  );
  dgc_sync_pulse uWake (
    .clock(clock),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .srcToggle(l_q.gcWakeTgl),
    .pulse(wakePulse)
  );

  typedef struct packed {
    logic [7:0] seqCnt;
    logic reload;
    logic wake;
  } dgc_sys_state_t;
  dgc_sys_state_t s_q;
  dgc_sys_state_t s_d;
  always_comb begin
    s_d = s_q;
    s_d.reload = 1'b0;
    s_d.wake = 1'b0;
    if (clkEn) begin
      if (rstPulse) begin
        // No delay timer, only the short load sequence [R11]
        s_d.reload = 1'b1; // [R10]
        s_d.seqCnt = `DGC_POR_SEQ_CYCLES;
      end else if (s_q.seqCnt != 8'h00) begin
        s_d.seqCnt = 8'(s_q.seqCnt - 8'h01);
      end
      s_d.wake = wakePulse; // [R13]
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign storeReload = s_q.reload;
  assign powerDownClear = s_q.wake;
  assign outputHold = s_q.seqCnt != 8'h00; // [R12]
  assign channelPowerDownSelectMask = '0;

  a_hold_after_reset: assert property (@(posedge clock) disable iff (!arst_n) // [R12]
    (clkEn && rstPulse) |=> outputHold[*8])
    else $error("output not held after general call reset");
  a_reload_one_cycle: assert property (@(posedge clock) disable iff (!arst_n) // [R10]
    (clkEn && rstPulse) |=> storeReload ##1 !storeReload)
    else $error("reload not a single pulse");
  a_wake_follows: assert property (@(posedge clock) disable iff (!arst_n) // [R13]
    (clkEn && wakePulse) |=> powerDownClear)
    else $error("wake pulse lost");
  a_gc_hw_ignored: assert property (@(negedge sclClk) disable iff (!arst_n) // [R8]
    (l_q.st == dgc_pkg::DGC_IGNORE) |-> !l_q.sdaDrv)
    else $error("driving SDA while ignoring");
  a_err_nack: assert property (@(negedge sclClk) disable iff (!arst_n) // [R5]
    (l_q.st == dgc_pkg::DGC_NACK_WAIT && !cond.start) |=> !l_q.sdaDrv)
    else $error("ACK after command error");
  a_start_clears: assert property (@(negedge sclClk) disable iff (!arst_n) // [R18]
    cond.start |=> (l_q.st == dgc_pkg::DGC_ADDR && !l_q.gcActive))
    else $error("start did not clear state");
  a_cmd_addr_kept: assert property (@(negedge sclClk) disable iff (!arst_n) // [R3]
    (l_q.st == dgc_pkg::DGC_CMD_ACK) |-> l_q.lastAddr == l_q.shift[7:3])
    else $error("address not retained");
  a_unsup_nack: assert property (@(negedge sclClk) disable iff (!arst_n) // [R9]
    (l_q.st == dgc_pkg::DGC_GC_BYTE && l_q.bitCnt == 4'h7 && !cond.start && !cond.stop &&
     (nextByte == `DGC_GC_UNSUP_A || nextByte == `DGC_GC_UNSUP_B)) |=> !l_q.sdaDrv)
    else $error("unsupported general call acknowledged");
endmodule : dgc_i2c_slave

// file: dgc_pkg.sv
// Types for the DAC I2C command slave.
// Assumes the defines header is included by users.
package dgc_pkg;
  typedef enum logic [3:0] {
    DGC_IDLE = 4'h0,
    DGC_ADDR = 4'h1,
    DGC_ADDR_ACK = 4'h3,
    DGC_CMD = 4'h2,
    DGC_CMD_ACK = 4'h6,
    DGC_RD_BYTE = 4'h7,
    DGC_RD_ACK = 4'h5,
    DGC_WR_BYTE = 4'h4,
    DGC_WR_ACK = 4'hC,
    DGC_GC_BYTE = 4'hD,
    DGC_GC_ACK = 4'hF,
    DGC_NACK_WAIT = 4'hE,
    DGC_IGNORE = 4'hA
  } dgc_state_t;
  typedef struct packed {
    logic start;
    logic stop;
  } dgc_cond_t;
  typedef struct packed {
    logic gcReset;
    logic gcWake;
  } dgc_evt_t;
endpackage : dgc_pkg

// file: dgc_sync_pulse.sv
// Toggle-based event crossing from the link domain to the system clock.
// Assumes srcToggle flips once per event and events are spaced apart.
`timescale 1ns/1ps
module dgc_sync_pulse (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic srcToggle,
  output logic pulse
);
  typedef struct packed {
    logic [2:0] sync;
  } dgc_sp_state_t;
  dgc_sp_state_t s_q;
  dgc_sp_state_t s_d;
  always_comb begin
    s_d = s_q;
    if (clkEn) begin
      s_d.sync = {s_q.sync[1:0], srcToggle};
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // Second and third stage differ on change; first stage read by nothing else
  assign pulse = clkEn & (s_q.sync[2] ^ s_q.sync[1]);
endmodule : dgc_sync_pulse
